// ### verilog/tbc_regs.svh
// Register map, field layout and timing constants of the clock mode block
`ifndef TBC_REGS_SVH
`define TBC_REGS_SVH
`define TBC_A_CMD        16'h0000
`define TBC_A_STAT       16'h0004
`define TBC_A_ERR        16'h0008
`define TBC_A_TSLOT      16'h000C
`define TBC_A_CFG0       16'h1F18
`define TBC_A_CFG1       16'h1F1C
`define TBC_F_MODE       2:0
`define TBC_F_SUB        6:4
`define TBC_F_ARGA       9:8
`define TBC_F_SRC        23:16
`define TBC_F_ARGC       27:24
`define TBC_F_STREAM     12:8
`define TBC_F_SLOT       6:0
`define TBC_F_NEWREP     8
`define TBC_F_REPCNT     23:16
`define TBC_F_REJ        9
`define TBC_F_ISDN_USED  23
`define TBC_MODE_NONE    3'h0
`define TBC_MODE_SLAVE   3'h1
`define TBC_MODE_PRI_A   3'h2
`define TBC_MODE_PRI_B   3'h3
`define TBC_MODE_SEC_A   3'h4
`define TBC_MODE_SEC_B   3'h5
`define TBC_SUB_MAX_PRI  3'h5
`define TBC_SUB_MAX_SEC  3'h3
`define TBC_SUB_FB_MIN   3'h4
`define TBC_SUB_AUTO     2
`define TBC_ARGA_MAX     2'h2
`define TBC_ARGA_NR1     2'h1
`define TBC_ARGA_NR2     2'h2
`define TBC_SRC_8K       8'h00
`define TBC_E_CLKA       0
`define TBC_E_CLKB       1
`define TBC_E_NREF       4
`define TBC_E_FRAME      5
`define TBC_NUM_MON      6
`define TBC_M_CLKA       0
`define TBC_M_CLKB       1
`define TBC_M_NR1        2
`define TBC_M_NR2        3
`define TBC_M_FRAME      4
`define TBC_M_ISDN       5
`define TBC_MON_W        16
`define TBC_CLK_HALF     2'h2
`define TBC_HCLK_KHZ     64'd40000
`define TBC_CLK_LOSS_NS  64'd800
`define TBC_FRAME_LOSS_NS 64'd250000
`define TBC_PS_PER_NS    64'd1000000
`endif

// ### verilog/tbc_pkg.sv
// Types shared by the clock mode control block
package tbc_pkg;
   typedef enum logic [3:0] {
      ST_LOCAL   = 4'b0001,
      ST_SLAVE   = 4'b0010,
      ST_PRIMARY = 4'b0100,
      ST_SECOND  = 4'b1000
   } tbc_state_t;
   typedef enum logic [2:0] {
      SRC_LOCAL = 3'h0,
      SRC_BUS_A = 3'h1,
      SRC_BUS_B = 3'h2,
      SRC_NR1   = 3'h3,
      SRC_NR2   = 3'h4,
      SRC_ISDN  = 3'h5,
      SRC_HOLD  = 3'h6
   } tbc_src_t;
   typedef struct packed {
      logic [3:0] argc;
      logic [7:0] src;
      logic [1:0] arga;
      logic [2:0] sub;
      logic [2:0] mode;
   } tbc_cmd_t;
   typedef struct packed {
      logic isdn_ref;
      logic frame;
      logic netref2;
      logic netref1;
      logic clk_b;
      logic clk_a;
   } tbc_sense_t;
   typedef struct packed {
      logic clk_a_o;
      logic clk_a_oe_n;
      logic clk_b_o;
      logic clk_b_oe_n;
      logic netref1_o;
      logic netref1_oe_n;
      logic netref2_o;
      logic netref2_oe_n;
   } tbc_drive_t;
endpackage

// ### verilog/tbc_clk_mon.sv
// Activity monitor for one backplane clock or reference pin
`timescale 1ns/1ps
`include "tbc_regs.svh"
module tbc_clk_mon
   import tbc_pkg::*;
#(
   parameter int TIMEOUT = 32
)
(
   input  wire logic hclk,    // System clock
   input  wire logic hresetn, // Async reset, active low
   input  wire logic pin,     // Raw pin from the backplane
   output logic      lvl,     // Synchronised pin level
   output logic      fault    // High while pin has been quiet too long
);
   localparam logic [`TBC_MON_W-1:0] LIM = `TBC_MON_W'(TIMEOUT);
   logic                 s1;
   logic                 s2;
   logic [`TBC_MON_W-1:0] cnt;
   logic [`TBC_MON_W-1:0] next_cnt;
   logic                 next_fault;

   always_comb begin
      next_cnt   = cnt;
      next_fault = fault;
      if (s2 != lvl) begin
         next_cnt   = '0;
         next_fault = 1'b0;
      end else if (cnt == LIM) begin
         next_fault = 1'b1;
      end else begin
         next_cnt = cnt + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1    <= 1'b0;
         s2    <= 1'b0;
         lvl   <= 1'b0;
         cnt   <= '0;
         fault <= 1'b0;
      end else begin
         s1    <= pin;
         s2    <= s1;
         lvl   <= s2;
         cnt   <= next_cnt;
         fault <= next_fault;
      end
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   mon_raise_a: assert property ($rose(fault) |-> $past(cnt) == LIM)
      else $error("fault rose before the quiet time ran out");
   mon_clear_a: assert property ((s2 != lvl) |=> !fault && cnt == '0)
      else $error("edge did not clear the fault");
endmodule

// ### verilog/tbc_err_rpt.sv
// Clock error bit field and change-driven report generation
`timescale 1ns/1ps
`include "tbc_regs.svh"
module tbc_err_rpt
   import tbc_pkg::*;
(
   input  wire logic                    hclk,    // System clock
   input  wire logic                    hresetn, // Async reset, active low
   input  wire logic [`TBC_NUM_MON-1:0] mfault,  // Monitor faults
   input  wire logic                    active,  // Bus clocking in use
   input  wire logic                    use_nr2, // Timing from reference two
   output logic      [5:0]              err,     // Clock error bits
   output logic                         report,  // New report, one cycle
   output logic      [7:0]              rep_cnt  // Reports raised so far
);
   logic [5:0] next_err;
   logic       next_report;
   logic [7:0] next_rep_cnt;

   always_comb begin
      next_err = '0;
      if (active) begin
         next_err[`TBC_E_CLKA]  = mfault[`TBC_M_CLKA];
         next_err[`TBC_E_CLKB]  = mfault[`TBC_M_CLKB];
         next_err[`TBC_E_NREF]  = use_nr2 ? mfault[`TBC_M_NR2]
                                          : mfault[`TBC_M_NR1];
         next_err[`TBC_E_FRAME] = mfault[`TBC_M_FRAME];
      end
      next_report  = (next_err != err);
      next_rep_cnt = rep_cnt + {7'h0_0, next_report};
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err     <= '0;
         report  <= 1'b0;
         rep_cnt <= '0;
      end else begin
         err     <= next_err;
         report  <= next_report;
         rep_cnt <= next_rep_cnt;
      end
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   err_change_a: assert property ($changed(err) |-> report
      && rep_cnt == $past(rep_cnt) + 8'h01)
      else $error("error change gave no report");
   legacy_zero_a: assert property (err[3:2] == 2'b00)
      else $error("legacy bus error bits set");
endmodule

// ### verilog/tbc_clock_ctrl.sv
// Backplane clock mode control with AHB-Lite register slave
// Operation
// - Reach all 32 streams, 128 slots
// - Slot code: stream high byte, slot low
// - Switch only once mode set, clock present
// - Power-up: local clock, no bus clocks
// - Decode modes 0 to 5
// - Slave submodes 0,1,6,7 pick clock A/B
// - Slave argument a enables reference output
// - Primary submodes 0-5 pick timing source
// - Reference frequency must be 00 (8 kHz)
// - Submodes 3-5: source picks ISDN port
// - Secondary locks opposite clock, drives own
// - Secondary takes over when primary fails
// - Secondary accepts submodes 0 to 3 only
// - Auto fallback to other clock, report it
// - Error bits per clock fault
// - Bit 4 follows reference in use
// - Error bits mirrored in config block byte 7
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "tbc_regs.svh"
module tbc_clock_ctrl
   import tbc_pkg::*;
#(
   parameter int FRAME_LOSS_CYC = int'((`TBC_FRAME_LOSS_NS *
      `TBC_HCLK_KHZ + `TBC_PS_PER_NS - 64'd1) / `TBC_PS_PER_NS)
)
(
   input  wire logic        hclk,       // 40 MHz system clock
   input  wire logic        hresetn,    // Async reset, active low
   input  wire logic        hsel,       // AHB slave select
   input  wire logic [31:0] haddr,      // AHB address
   input  wire logic [1:0]  htrans,     // AHB transfer type
   input  wire logic        hwrite,     // AHB write
   input  wire logic [2:0]  hsize,      // AHB size, word only
   input  wire logic [31:0] hwdata,     // AHB write data
   input  wire logic        hready,     // AHB bus ready
   output logic      [31:0] hrdata,     // AHB read data
   output logic             hreadyout,  // AHB slave ready
   output logic             hresp,      // AHB response, always OKAY
   input  tbc_sense_t       bus_sense,  // Backplane clock inputs
   output tbc_drive_t       bus_drive,  // Backplane clock drives
   output tbc_src_t         pll_src,    // Timing source of the PLL
   output logic      [4:0]  ts_stream,  // Selected bus stream
   output logic      [6:0]  ts_slot,    // Selected bus timeslot
   output logic             switch_en,  // Bus switching permitted
   output logic             err_report, // Clock error report pulse
   output logic      [5:0]  err_bits    // Current clock error bits
);
   localparam int CLK_LOSS_CYC = int'((`TBC_CLK_LOSS_NS * `TBC_HCLK_KHZ
      + `TBC_PS_PER_NS - 64'd1) / `TBC_PS_PER_NS);

   tbc_state_t state, next_state;
   tbc_src_t   next_src;
   tbc_cmd_t   cmd, next_cmd, w_cmd;
   tbc_drive_t next_drv;
   logic       configured, next_configured;
   logic       fell_back, next_fell_back;
   logic       takeover, next_takeover;
   logic       rej, next_rej;
   logic       newrep, next_newrep;
   logic [15:0] tslot, next_tslot;
   logic       next_switch_en;
   logic [1:0] div, next_div;
   logic       clk_out, next_clk_out;
   logic       wr_pend, next_wr_pend;
   logic [15:0] wr_addr, next_wr_addr;
   logic [31:0] next_hrdata;
   logic       cmd_wr, cmd_ok, is_pri, is_sec, acc;
   logic       sel_b, opp_b, use_nr2, drv_on;
   logic [5:0] err;
   logic       report;
   logic [7:0] rep_cnt;
   logic [`TBC_NUM_MON-1:0] mfault, mlvl, mpin;

   assign mpin = bus_sense;

   genvar gi;
   generate
      for (gi = 0; gi < `TBC_NUM_MON; gi++) begin : g_mon
         tbc_clk_mon #(
            .TIMEOUT((gi == `TBC_M_FRAME) ? FRAME_LOSS_CYC : CLK_LOSS_CYC)
         ) u_mon (
            .hclk    (hclk),
            .hresetn (hresetn),
            .pin     (mpin[gi]),
            .lvl     (mlvl[gi]),
            .fault   (mfault[gi])
         );
      end
   endgenerate

   tbc_err_rpt u_err (
      .hclk    (hclk),
      .hresetn (hresetn),
      .mfault  (mfault),
      .active  (state != ST_LOCAL),
      .use_nr2 (use_nr2),
      .err     (err),
      .report  (report),
      .rep_cnt (rep_cnt)
   );

   // Zero-wait slave: writes land in the data phase after the address
   assign acc    = hsel && htrans[1] && hready;
   assign cmd_wr = wr_pend && (wr_addr == `TBC_A_CMD);
   assign w_cmd  = '{argc: hwdata[`TBC_F_ARGC], src: hwdata[`TBC_F_SRC],
                     arga: hwdata[`TBC_F_ARGA], sub: hwdata[`TBC_F_SUB],
                     mode: hwdata[`TBC_F_MODE]};
   assign is_pri = (w_cmd.mode == `TBC_MODE_PRI_A) ||
                   (w_cmd.mode == `TBC_MODE_PRI_B);
   assign is_sec = (w_cmd.mode == `TBC_MODE_SEC_A) ||
                   (w_cmd.mode == `TBC_MODE_SEC_B);
   assign sel_b  = cmd.sub[0] ^ fell_back;
   assign opp_b  = (cmd.mode == `TBC_MODE_SEC_A);
   assign use_nr2 = (pll_src == SRC_NR2);

   always_comb begin
      cmd_ok = 1'b0;
      if (w_cmd.mode == `TBC_MODE_NONE) begin
         cmd_ok = 1'b1;
      end else if (w_cmd.mode == `TBC_MODE_SLAVE) begin
         cmd_ok = (w_cmd.sub[2:1] == 2'b00 || w_cmd.sub[2:1] == 2'b11)
                  && (w_cmd.arga <= `TBC_ARGA_MAX);
      end else if (is_pri || is_sec) begin
         cmd_ok = (w_cmd.arga == 2'h0)
            && (w_cmd.sub <= (is_sec ? `TBC_SUB_MAX_SEC
                                     : `TBC_SUB_MAX_PRI))
            && !((w_cmd.sub == 3'h1 || w_cmd.sub == 3'h2)
                 && w_cmd.src != `TBC_SRC_8K);
      end
   end

   always_comb begin
      next_state      = state;
      next_cmd        = cmd;
      next_configured = configured;
      next_fell_back  = fell_back;
      next_takeover   = takeover;
      next_rej        = rej;
      if (wr_pend && wr_addr == `TBC_A_STAT && hwdata[`TBC_F_REJ])
         next_rej = 1'b0;
      if (cmd_wr && cmd_ok) begin
         // A fresh command drops any fallback or takeover history
         next_cmd        = w_cmd;
         next_configured = 1'b1;
         next_fell_back  = 1'b0;
         next_takeover   = 1'b0;
         case (w_cmd.mode)
            `TBC_MODE_SLAVE: next_state = ST_SLAVE;
            `TBC_MODE_PRI_A, `TBC_MODE_PRI_B: next_state = ST_PRIMARY;
            `TBC_MODE_SEC_A, `TBC_MODE_SEC_B: next_state = ST_SECOND;
            default: next_state = ST_LOCAL;
         endcase
      end else if (cmd_wr) begin
         next_rej = 1'b1;
      end else begin
         case (state)
            ST_SLAVE: begin
               if (cmd.sub[`TBC_SUB_AUTO] && !fell_back
                   && mfault[sel_b] && !mfault[!sel_b])
                  next_fell_back = 1'b1;
            end
            ST_SECOND: begin
               if (mfault[opp_b]) begin
                  next_state    = ST_PRIMARY;
                  next_takeover = 1'b1;
               end
            end
            ST_PRIMARY: begin
               if (cmd.sub >= `TBC_SUB_FB_MIN && !fell_back
                   && mfault[`TBC_M_ISDN])
                  next_fell_back = 1'b1;
            end
            ST_LOCAL: ;
            default: next_state = ST_LOCAL;
         endcase
      end
   end

   always_comb begin
      next_src = SRC_LOCAL;
      case (next_state)
         ST_SLAVE:
            next_src = (next_cmd.sub[0] ^ next_fell_back) ? SRC_BUS_B
                                                           : SRC_BUS_A;
         ST_SECOND:
            next_src = (next_cmd.mode == `TBC_MODE_SEC_A) ? SRC_BUS_B
                                                           : SRC_BUS_A;
         ST_PRIMARY: begin
            case (next_cmd.sub)
               3'h0: next_src = next_takeover ? SRC_HOLD : SRC_LOCAL;
               3'h1: next_src = SRC_NR1;
               3'h2: next_src = SRC_NR2;
               3'h3: next_src = SRC_ISDN;
               3'h4: next_src = next_fell_back ? SRC_NR1 : SRC_ISDN;
               3'h5: next_src = next_fell_back ? SRC_NR2 : SRC_ISDN;
               default: next_src = SRC_LOCAL;
            endcase
         end
         default: next_src = SRC_LOCAL;
      endcase
      drv_on = (next_state == ST_PRIMARY) || (next_state == ST_SECOND);
      // No PLL here: the driven clock is a divided hclk stand-in
      next_div     = (div == `TBC_CLK_HALF - 2'h1) ? 2'h0 : div + 2'h1;
      next_clk_out = (div == `TBC_CLK_HALF - 2'h1) ? !clk_out : clk_out;
      next_drv.clk_a_o      = clk_out;
      next_drv.clk_b_o      = clk_out;
      next_drv.clk_a_oe_n   = !(drv_on && !next_cmd.mode[0]);
      next_drv.clk_b_oe_n   = !(drv_on && next_cmd.mode[0]);
      next_drv.netref1_o    = mlvl[`TBC_M_ISDN];
      next_drv.netref2_o    = mlvl[`TBC_M_ISDN];
      next_drv.netref1_oe_n = !(next_state == ST_SLAVE
                                && next_cmd.arga == `TBC_ARGA_NR1);
      next_drv.netref2_oe_n = !(next_state == ST_SLAVE
                                && next_cmd.arga == `TBC_ARGA_NR2);
      case (next_state)
         ST_SLAVE:   next_switch_en = !mfault[next_src == SRC_BUS_B];
         ST_SECOND:  next_switch_en = !mfault[next_src == SRC_BUS_B];
         ST_PRIMARY: next_switch_en = 1'b1;
         default:    next_switch_en = 1'b0;
      endcase
   end

   always_comb begin
      next_wr_pend = acc && hwrite && (haddr[31:16] == 16'h0000);
      next_wr_addr = haddr[15:0];
      next_tslot   = tslot;
      if (wr_pend && wr_addr == `TBC_A_TSLOT) begin
         next_tslot = '0;
         next_tslot[`TBC_F_STREAM] = hwdata[`TBC_F_STREAM];
         next_tslot[`TBC_F_SLOT]   = hwdata[`TBC_F_SLOT];
      end
      next_newrep = newrep;
      if (wr_pend && wr_addr == `TBC_A_ERR && hwdata[`TBC_F_NEWREP])
         next_newrep = 1'b0;
      if (report)
         next_newrep = 1'b1;
      // Reads see next values so a write then read stays coherent
      next_hrdata = '0;
      if (acc && !hwrite && haddr[31:16] == 16'h0000) begin
         case (haddr[15:0])
            `TBC_A_CMD: begin
               next_hrdata[`TBC_F_MODE] = next_cmd.mode;
               next_hrdata[`TBC_F_SUB]  = next_cmd.sub;
               next_hrdata[`TBC_F_ARGA] = next_cmd.arga;
               next_hrdata[`TBC_F_SRC]  = next_cmd.src;
               next_hrdata[`TBC_F_ARGC] = next_cmd.argc;
            end
            `TBC_A_STAT:
               next_hrdata[12:0] = {next_switch_en, next_takeover,
                  next_fell_back, next_rej, next_configured, 1'b0,
                  next_src, next_state};
            `TBC_A_ERR: begin
               next_hrdata[5:0]             = err;
               next_hrdata[`TBC_F_NEWREP]   = next_newrep;
               next_hrdata[`TBC_F_REPCNT]   = rep_cnt;
            end
            `TBC_A_TSLOT: next_hrdata[15:0] = next_tslot;
            `TBC_A_CFG0:
               next_hrdata = {next_cmd.src, 6'h00, next_cmd.arga,
                              5'h00, next_cmd.sub, 5'h00, next_cmd.mode};
            `TBC_A_CFG1: begin
               next_hrdata[`TBC_F_ISDN_USED] = (next_src == SRC_ISDN);
               next_hrdata[19:16] = (next_src == SRC_ISDN)
                                    ? next_cmd.src[3:0] : 4'h0;
               next_hrdata[29:24] = err;
            end
            default: next_hrdata = '0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state      <= ST_LOCAL;
         pll_src    <= SRC_LOCAL;
         cmd        <= '0;
         configured <= 1'b0;
         fell_back  <= 1'b0;
         takeover   <= 1'b0;
         rej        <= 1'b0;
         newrep     <= 1'b0;
         tslot      <= '0;
         switch_en  <= 1'b0;
         div        <= '0;
         clk_out    <= 1'b0;
         bus_drive  <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
         wr_pend    <= 1'b0;
         wr_addr    <= '0;
         hrdata     <= '0;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         ts_stream  <= '0;
         ts_slot    <= '0;
         err_report <= 1'b0;
         err_bits   <= '0;
      end else begin
         state      <= next_state;
         pll_src    <= next_src;
         cmd        <= next_cmd;
         configured <= next_configured;
         fell_back  <= next_fell_back;
         takeover   <= next_takeover;
         rej        <= next_rej;
         newrep     <= next_newrep;
         tslot      <= next_tslot;
         switch_en  <= next_switch_en;
         div        <= next_div;
         clk_out    <= next_clk_out;
         bus_drive  <= next_drv;
         wr_pend    <= next_wr_pend;
         wr_addr    <= next_wr_addr;
         hrdata     <= next_hrdata;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         ts_stream  <= next_tslot[`TBC_F_STREAM];
         ts_slot    <= next_tslot[`TBC_F_SLOT];
         err_report <= report;
         err_bits   <= err;
      end
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   local_idle_a: assert property (!configured |-> state == ST_LOCAL
      && bus_drive.clk_a_oe_n && bus_drive.clk_b_oe_n)
      else $error("bus clock driven before any mode set");
   slave_fall_a: assert property (state == ST_SLAVE && !cmd_wr
      && cmd.sub[`TBC_SUB_AUTO] && !fell_back && mfault[sel_b]
      && !mfault[!sel_b] |=> fell_back
      && pll_src != $past(pll_src))
      else $error("slave did not fall back to the other clock");
   take_over_a: assert property (state == ST_SECOND && !cmd_wr
      && mfault[opp_b] |=> state == ST_PRIMARY && takeover)
      else $error("secondary did not take over");
   sec_drive_a: assert property (state == ST_SECOND |->
      (opp_b ? (!bus_drive.clk_a_oe_n && bus_drive.clk_b_oe_n)
             : (!bus_drive.clk_b_oe_n && bus_drive.clk_a_oe_n)))
      else $error("secondary drives the wrong clock");
   bad_cmd_a: assert property (cmd_wr && !cmd_ok |=> $stable(cmd)
      && rej)
      else $error("invalid command was taken");
   switch_gate_a: assert property (switch_en |-> configured
      && state != ST_LOCAL)
      else $error("switching enabled without bus clock");
   netref_en_a: assert property (state == ST_SLAVE
      && cmd.arga == `TBC_ARGA_NR1 |-> !bus_drive.netref1_oe_n)
      else $error("reference output one not enabled");
   cov_fall_c: cover property (state == ST_SLAVE ##1 $rose(fell_back));
   cov_take_c: cover property ($rose(takeover));
   cov_rep_c: cover property (err_report && err_bits != 6'h00);
endmodule

// ### bench/tbc_peer.sv
// Peer boards that drive the backplane clocks and references
`timescale 1ns/1ps
module tbc_peer
   import tbc_pkg::*;
(
   input  wire logic [5:0] stop,  // Pins whose source has failed
   output tbc_sense_t      sense  // Pin levels seen by the block
);
   logic lclk = 1'b0;
   initial begin
      forever #100 lclk = ~lclk;
   end
   // One peer masters every line; a failed source freezes its pin low
   always_comb begin
      sense = tbc_sense_t'({6{lclk}} & ~stop);
   end
endmodule

// ### bench/tbc_clock_ctrl_tb.sv
// Self-checking bench of the clock mode control block
`timescale 1ns/1ps
`include "tbc_regs.svh"
module tbc_clock_ctrl_tb
   import tbc_pkg::*;
;
   logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q, d;
   logic        hreadyout, hresp, switch_en, err_report;
   logic [5:0]  stop = '0, err_bits;
   logic [4:0]  ts_stream;
   logic [6:0]  ts_slot;
   logic [31:0] bad [4];
   tbc_sense_t  sense;
   tbc_drive_t  bus_drive;
   tbc_src_t    pll_src;
   int          errors = 0, checks_done = 0, cyc = 0, s;
   tbc_peer peer (.stop(stop), .sense(sense));
   tbc_clock_ctrl #(.FRAME_LOSS_CYC(100)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .bus_sense(sense), .bus_drive(bus_drive),
      .pll_src(pll_src), .ts_stream(ts_stream), .ts_slot(ts_slot),
      .switch_en(switch_en), .err_report(err_report), .err_bits(err_bits));
   initial begin
      forever #12.5 hclk = ~hclk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // A hung handshake must still end in the verdict
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, dw);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= dw;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   function automatic logic [31:0] cw(int m, sb, a, b);
      return {8'h00, 8'(b), 6'h00, 2'(a), 1'b0, 3'(sb), 1'b0, 3'(m)};
   endfunction
   function automatic tbc_src_t exp_src(int m, sb);
      if (m == 1) return sb[0] ? SRC_BUS_B : SRC_BUS_A;
      if (m >= 4) return m == 4 ? SRC_BUS_B : SRC_BUS_A;
      return sb == 0 ? SRC_LOCAL : sb == 1 ? SRC_NR1 :
             sb == 2 ? SRC_NR2 : SRC_ISDN;
   endfunction
   task automatic setc(input int m, sb, a, b);
      bus(1, `TBC_A_CMD, cw(m, sb, a, b));
      repeat (2) @(posedge hclk);
   endtask
   task automatic wait_err();
      for (int n = 0; n < 400 && err_report !== 1'b1; n++)
         @(posedge hclk);
      chk(err_report, 1);
      repeat (2) @(posedge hclk);
   endtask
   initial begin
      void'($urandom(57));
      bad = '{cw(6, 0, 0, 0), cw(4, 4, 0, 0), cw(2, 1, 0, 1), cw(2, 0, 1, 0)};
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(pll_src, SRC_LOCAL);
      chk(bus_drive, 8'h55);
      chk(switch_en, 0);
      $display("reset test done");
      for (int i = 0; i < 6; i++) begin
         setc(1, i % 2, i / 2, 0);
         chk(pll_src, exp_src(1, i % 2));
         chk({bus_drive.netref1_oe_n, bus_drive.netref2_oe_n},
             {i / 2 != 1, i / 2 != 2});
         chk(switch_en, 1);
         bus(0, `TBC_A_CFG0, 0);
         chk(q, {8'h00, 8'(i / 2), 8'(i % 2), 8'h01});
      end
      $display("slave test done");
      for (int m = 2; m < 6; m++) begin
         s = $urandom_range(m < 4 ? 5 : 3);
         setc(m, s, 0, 0);
         chk(pll_src, exp_src(m, s));
         chk({bus_drive.clk_a_oe_n, bus_drive.clk_b_oe_n},
             {m % 2 == 1, m % 2 == 0});
      end
      foreach (bad[k]) begin
         bus(1, `TBC_A_STAT, 32'h0000_0200);
         bus(1, `TBC_A_CMD, bad[k]);
         bus(0, `TBC_A_STAT, 0);
         chk({q[9], q[3:0]}, 5'h18);
      end
      $display("master test done");
      setc(5, 1, 0, 0);
      stop <= 6'h01;
      wait_err();
      chk(pll_src, SRC_NR1);
      chk(bus_drive.clk_b_oe_n, 0);
      for (int k = 0; k < 3; k++) begin
         stop <= 6'h00;
         wait_err();
         setc(1, 6, 0, 0);
         bus(1, `TBC_A_ERR, 32'h0000_0100);
         stop <= k == 0 ? 6'h01 : k == 1 ? 6'h02 : 6'h10;
         wait_err();
         d = k == 0 ? 32'h01 : k == 1 ? 32'h02 : 32'h20;
         chk(err_bits, d);
         chk(pll_src, k == 0 ? SRC_BUS_B : SRC_BUS_A);
         bus(0, `TBC_A_CFG1, 0);
         chk(q[31:24], d);
         bus(0, `TBC_A_ERR, 0);
         chk(q[8], 1);
      end
      stop <= 6'h00;
      wait_err();
      setc(2, 2, 0, 0);
      stop <= 6'h04;
      repeat (100) @(posedge hclk);
      chk(err_bits, 0);
      stop <= 6'h08;
      wait_err();
      chk(err_bits, 6'h10);
      setc(2, 4, 0, 0);
      stop <= 6'h20;
      repeat (60) @(posedge hclk);
      chk(pll_src, SRC_NR1);
      $display("fault test done");
      for (int k = 0; k < 4; k++) begin
         d = k == 0 ? 32'h0000_1F7F : $urandom & 32'h0000_1F7F;
         bus(1, `TBC_A_TSLOT, d);
         bus(0, `TBC_A_TSLOT, 0);
         chk(q, d);
         chk({hreadyout, hresp}, 2'b10);
         chk({ts_stream, ts_slot}, {d[12:8], d[6:0]});
      end
      bus(0, 32'h0000_0040, 0);
      chk(q, 0);
      $display("timeslot test done");
      report_and_stop();
   end
endmodule
